// *** otp_pkg.sv ***
// Constants, field positions and types shared by the OTP security block
package otp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int unsigned OTP_WORD_W          = 32;
  localparam int unsigned OTP_SECTORS         = 4;
  localparam int unsigned OTP_ROWS_PER_SECTOR = 512;
  localparam int unsigned OTP_MAIN_ROWS       = OTP_SECTORS * OTP_ROWS_PER_SECTOR;
  localparam int unsigned OTP_REDUN_ROWS      = 16;
  localparam int unsigned OTP_ADDR_W          = 12;
  localparam int unsigned OTP_PORT_AW         = 24;
  localparam logic [11:0] OTP_SEC_ROW         = 12'hFFF;
  localparam logic [11:0] OTP_FIRST_ROW       = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Port resource identifiers, used as register addresses
  localparam logic [23:0] RID_ADDR  = 24'h100200;
  localparam logic [23:0] RID_DATA  = 24'h200100;
  localparam logic [23:0] RID_CTRL  = 24'h100300;
  localparam logic [23:0] RID_SEC   = 24'h200200;
  localparam logic [23:0] RID_RDATA = 24'h200300;

  ////////////////////////////////////////////////////////////////////////////
  // Control port commands
  localparam logic [15:0] CMD_PROGRAM  = 16'h0001;
  localparam logic [15:0] CMD_PROG_SEC = 16'h0002;
  localparam logic [15:0] CMD_READ     = 16'h0004;

  ////////////////////////////////////////////////////////////////////////////
  // Protection configuration bit positions
  localparam int unsigned SB_JTAG_OFF  = 0;
  localparam int unsigned SB_LINK_OFF  = 1;
  localparam int unsigned SB_SEC_BOOT  = 5;
  localparam int unsigned SB_REDUN     = 7;
  localparam int unsigned SB_LOCK0     = 8;
  localparam int unsigned SB_MASTER    = 12;
  localparam int unsigned SB_JTAG_OTP  = 13;
  localparam int unsigned SB_DEBUG_OFF = 14;
  localparam int unsigned SB_USER_LO   = 15;
  localparam int unsigned SB_USER_HI   = 21;
  localparam int unsigned SB_UID_LO    = 22;
  localparam int unsigned SB_UID_HI    = 31;

  // Status bits returned when the control port is read
  localparam int unsigned ST_BIT_BUSY    = 0;
  localparam int unsigned ST_BIT_REFUSED = 1;
  localparam int unsigned ST_BIT_LOADED  = 2;
  localparam int unsigned ST_BIT_BOOTED  = 3;

  // Values after reset
  localparam logic [31:0] SEC_RST  = 32'h00000000;
  localparam logic [15:0] PORT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [3:0] {
    OTP_LOAD_RD,
    OTP_LOAD_WT,
    OTP_COPY_RD,
    OTP_COPY_WR,
    OTP_IDLE,
    OTP_FETCH,
    OTP_COMMIT
  } otp_state_t;

endpackage

// *** otp_array_mem.sv ***
// One-time-programmable cell array model with registered read data
`timescale 1ns/100ps
module otp_array_mem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 32
) (
  // Clock
  input  wire logic          i_clock,
  // Access
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  // Blank cells read as zero, as on an unprogrammed part
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      cells[i] = '0;
    end
  end

  // Write through a port, read data registered
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      cells[i_addr] <= i_wdata;
    end
    o_rdata <= cells[i_addr];
  end

endmodule

// *** otp_security_config.sv ***
// Per-tile OTP array, protection configuration load and boot copy
//
// Function
// - Array of 8 KB: four sectors of 512 rows, 32-bit words.
// - Protection configuration loads from OTP at power up before taking effect.
// - Remaining OTP data copied to SRAM before the processor runs.
// - Programming address written through 16-bit port id 0x100200.
// - Programming data written through 32-bit port id 0x200100.
// - Programming commands issued through 16-bit port id 0x100300.
// - Bit 0 disables the JTAG interface.
// - Bit 1 refuses other tiles access over the switch.
// - Bit 5 forces boot from OTP address 0, bypassing boot ROM.
// - Bit 7 enables the redundant OTP rows.
// - Bits 8 to 11 lock programming of sectors 0 to 3.
// - Bit 12 rejects all programming, protection row included.
// - Bit 13 blocks JTAG reads and writes of the OTP.
// - Bit 14 disables the global debug sync pin.
// - Bits 15 to 21 are user fields readable by software.
// - Bits 22 to 31 extend the JTAG user identification code.
// - JTAG user-code field comes from bits 22 to 31, zero when blank.
`timescale 1ns/100ps
module otp_security_config
  import otp_pkg::*;
#(
  parameter int unsigned COPY_WORDS = OTP_MAIN_ROWS
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  // Processor I/O port access
  input  wire logic [23:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // JTAG access to the array
  input  wire logic        i_jtag_req,
  input  wire logic        i_jtag_we,
  input  wire logic [15:0] i_jtag_addr,
  input  wire logic [31:0] i_jtag_wdata,
  output logic             o_jtag_ready,
  output logic             o_jtag_ack,
  output logic      [31:0] o_jtag_rdata,
  // Boot copy into SRAM
  output logic             o_sram_we,
  output logic      [10:0] o_sram_addr,
  output logic      [31:0] o_sram_wdata,
  output logic             o_proc_hold,
  // Protection effects
  output logic             o_secure_boot,
  output logic             o_jtag_enable,
  output logic             o_link_access_en,
  output logic             o_debug_sync_en,
  output logic             o_redundant_en,
  output logic      [6:0]  o_user_field,
  output logic      [9:0]  o_usercode_ext
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // The copy walks main rows only
  if (COPY_WORDS == 0 || COPY_WORDS > OTP_MAIN_ROWS) begin : g_bad_copy
    $error("COPY_WORDS must lie between 1 and the number of main rows");
  end

  localparam logic [11:0] COPY_LAST = 12'(COPY_WORDS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    otp_state_t  st;
    logic [11:0] op_addr;
    logic [31:0] op_data;
    logic        op_wr;
    logic        op_jtag;
    logic [15:0] addr_port;
    logic [31:0] data_port;
    logic [31:0] sec;
    logic        loaded;
    logic        booted;
    logic        refused;
    logic [31:0] result;
    logic [31:0] bus_rdata;
    logic        jtag_ack;
    logic [31:0] jtag_rdata;
    logic        sram_we;
    logic [10:0] sram_addr;
    logic [31:0] sram_wdata;
  } otp_regs_t;

  otp_regs_t   s_r;
  otp_regs_t   s_nxt;

  logic        mem_we;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic        ctrl_wr;
  logic        jtag_path_ok;
  logic        jtag_allowed;

  ////////////////////////////////////////////////////////////////////////////
  // Address checks

  // Main rows always exist; redundant rows only once enabled
  function automatic logic row_ok(input logic [15:0] a, input logic [31:0] sec);
    logic main_row;
    logic spare_row;
    main_row  = a < 16'(OTP_MAIN_ROWS);
    spare_row = sec[SB_REDUN] && !main_row && a < 16'(OTP_MAIN_ROWS + OTP_REDUN_ROWS);
    row_ok    = main_row || spare_row;
  endfunction

  // Sector of a main row comes from the top two row bits
  function automatic logic prog_ok(input logic [15:0] a, input logic [31:0] sec);
    logic locked;
    locked  = a < 16'(OTP_MAIN_ROWS) && sec[SB_LOCK0 + 32'(a[10:9])];
    prog_ok = !sec[SB_MASTER] && !locked && row_ok(a, sec);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cell array

  otp_array_mem #(
    .AW (OTP_ADDR_W),
    .DW (OTP_WORD_W)
  ) u_cells (
    .i_clock (i_clock),
    .i_we    (mem_we),
    .i_addr  (s_r.op_addr),
    .i_wdata (mem_wdata),
    .o_rdata (mem_rdata)
  );

  // Programming only sets bits; blank zeros turn to ones
  assign mem_wdata = mem_rdata | s_r.op_data;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  // Control port write is the command strobe
  assign ctrl_wr = i_wr && i_addr == RID_CTRL;

  // JTAG sees the array only when neither lock bit is set
  assign jtag_path_ok = !s_r.sec[SB_JTAG_OFF] && !s_r.sec[SB_JTAG_OTP];

  // Writes need an unlocked row, reads only a valid one
  assign jtag_allowed = jtag_path_ok &&
                        (i_jtag_we ? prog_ok(i_jtag_addr, s_r.sec) : row_ok(i_jtag_addr, s_r.sec));

  // JTAG waits while a port command is being taken
  assign o_jtag_ready = s_r.st == OTP_IDLE && !ctrl_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt            = s_r;
    s_nxt.jtag_ack   = 1'b0;
    s_nxt.sram_we    = 1'b0;
    s_nxt.bus_rdata  = '0;
    mem_we           = 1'b0;

    // Address and data ports hold their value until rewritten
    if (i_wr && i_addr == RID_ADDR) begin
      s_nxt.addr_port = i_wdata[15:0];
    end
    if (i_wr && i_addr == RID_DATA) begin
      s_nxt.data_port = i_wdata;
    end

    // Read data stand for exactly one cycle, zero when unmapped
    if (i_rd) begin
      case (i_addr)
        RID_ADDR: begin
          s_nxt.bus_rdata = {16'h0000, s_r.addr_port};
        end
        RID_DATA: begin
          s_nxt.bus_rdata = s_r.data_port;
        end
        RID_CTRL: begin
          s_nxt.bus_rdata                 = '0;
          s_nxt.bus_rdata[ST_BIT_BUSY]    = s_r.st != OTP_IDLE;
          s_nxt.bus_rdata[ST_BIT_REFUSED] = s_r.refused;
          s_nxt.bus_rdata[ST_BIT_LOADED]  = s_r.loaded;
          s_nxt.bus_rdata[ST_BIT_BOOTED]  = s_r.booted;
        end
        RID_SEC: begin
          s_nxt.bus_rdata = s_r.sec;
        end
        RID_RDATA: begin
          s_nxt.bus_rdata = s_r.result;
        end
        default: begin
          s_nxt.bus_rdata = '0;
        end
      endcase
    end

    // A command while busy is dropped and flagged
    if (ctrl_wr && s_r.st != OTP_IDLE) begin
      s_nxt.refused = 1'b1;
    end

    case (s_r.st)
      // Fetch the protection row before anything else may act
      OTP_LOAD_RD: begin
        s_nxt.st = OTP_LOAD_WT;
      end
      OTP_LOAD_WT: begin
        s_nxt.sec     = mem_rdata;
        s_nxt.loaded  = 1'b1;
        s_nxt.op_addr = OTP_FIRST_ROW;
        s_nxt.st      = OTP_COPY_RD;
      end
      // Two cycles a word keeps the copy simple; boot is rare
      OTP_COPY_RD: begin
        s_nxt.st = OTP_COPY_WR;
      end
      OTP_COPY_WR: begin
        s_nxt.sram_we    = 1'b1;
        s_nxt.sram_addr  = s_r.op_addr[10:0];
        s_nxt.sram_wdata = mem_rdata;
        if (s_r.op_addr == COPY_LAST) begin
          s_nxt.booted = 1'b1;
          s_nxt.st     = OTP_IDLE;
        end else begin
          s_nxt.op_addr = s_r.op_addr + 12'h001;
          s_nxt.st      = OTP_COPY_RD;
        end
      end
      // Port commands take priority over JTAG
      OTP_IDLE: begin
        if (ctrl_wr) begin
          s_nxt.refused = 1'b0;
          s_nxt.op_jtag = 1'b0;
          s_nxt.op_data = s_r.data_port;
          case (i_wdata[15:0])
            CMD_PROGRAM: begin
              if (prog_ok(s_r.addr_port, s_r.sec)) begin
                s_nxt.op_addr = s_r.addr_port[11:0];
                s_nxt.op_wr   = 1'b1;
                s_nxt.st      = OTP_FETCH;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
            CMD_PROG_SEC: begin
              // New protection row only takes effect at next power up
              if (!s_r.sec[SB_MASTER]) begin
                s_nxt.op_addr = OTP_SEC_ROW;
                s_nxt.op_wr   = 1'b1;
                s_nxt.st      = OTP_FETCH;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
            CMD_READ: begin
              if (row_ok(s_r.addr_port, s_r.sec)) begin
                s_nxt.op_addr = s_r.addr_port[11:0];
                s_nxt.op_wr   = 1'b0;
                s_nxt.st      = OTP_FETCH;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
            default: begin
              s_nxt.refused = 1'b1;
            end
          endcase
        end else if (i_jtag_req) begin
          if (jtag_allowed) begin
            s_nxt.op_jtag = 1'b1;
            s_nxt.op_addr = i_jtag_addr[11:0];
            s_nxt.op_data = i_jtag_wdata;
            s_nxt.op_wr   = i_jtag_we;
            s_nxt.st      = OTP_FETCH;
          end else begin
            // Refused JTAG access answers at once with zero data
            s_nxt.jtag_ack   = 1'b1;
            s_nxt.jtag_rdata = '0;
          end
        end
      end
      OTP_FETCH: begin
        s_nxt.st = OTP_COMMIT;
      end
      // Old word is on the read port: merge and write, or return it
      OTP_COMMIT: begin
        mem_we = s_r.op_wr;
        if (!s_r.op_wr && s_r.op_jtag) begin
          s_nxt.jtag_rdata = mem_rdata;
        end else if (!s_r.op_wr) begin
          s_nxt.result = mem_rdata;
        end
        s_nxt.jtag_ack = s_r.op_jtag;
        s_nxt.st       = OTP_IDLE;
      end
      default: begin
        s_nxt.st = OTP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Protection starts at zero but stays inert until the load completes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r.st         <= OTP_LOAD_RD;
      s_r.op_addr    <= OTP_SEC_ROW;
      s_r.op_data    <= '0;
      s_r.op_wr      <= 1'b0;
      s_r.op_jtag    <= 1'b0;
      s_r.addr_port  <= PORT_RST;
      s_r.data_port  <= '0;
      s_r.sec        <= SEC_RST;
      s_r.loaded     <= 1'b0;
      s_r.booted     <= 1'b0;
      s_r.refused    <= 1'b0;
      s_r.result     <= '0;
      s_r.bus_rdata  <= '0;
      s_r.jtag_ack   <= 1'b0;
      s_r.jtag_rdata <= '0;
      s_r.sram_we    <= 1'b0;
      s_r.sram_addr  <= '0;
      s_r.sram_wdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus and JTAG answers
  assign o_rdata      = s_r.bus_rdata;
  assign o_jtag_ack   = s_r.jtag_ack;
  assign o_jtag_rdata = s_r.jtag_rdata;

  // Boot copy; processor held until the last word lands
  assign o_sram_we    = s_r.sram_we;
  assign o_sram_addr  = s_r.sram_addr;
  assign o_sram_wdata = s_r.sram_wdata;
  assign o_proc_hold  = !s_r.booted;

  // Enables stay off until the configuration is known
  assign o_secure_boot    = s_r.loaded && s_r.sec[SB_SEC_BOOT];
  assign o_jtag_enable    = s_r.loaded && !s_r.sec[SB_JTAG_OFF];
  assign o_link_access_en = s_r.loaded && !s_r.sec[SB_LINK_OFF];
  assign o_debug_sync_en  = s_r.loaded && !s_r.sec[SB_DEBUG_OFF];
  assign o_redundant_en   = s_r.loaded && s_r.sec[SB_REDUN];

  // User fields; blank array gives zero
  assign o_user_field   = s_r.sec[SB_USER_HI:SB_USER_LO];
  assign o_usercode_ext = s_r.sec[SB_UID_HI:SB_UID_LO];

endmodule

// *** otp_sec_checker.sv ***
// Port assertions for the OTP protection block
`timescale 1ns/100ps
module otp_sec_checker
  import otp_pkg::*;
#(
  parameter int unsigned COPY_WORDS = OTP_MAIN_ROWS
) (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rstn,
  // Bus and JTAG
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_jtag_req,
  input wire logic        o_jtag_ready,
  input wire logic        o_jtag_ack,
  input wire logic [31:0] o_jtag_rdata,
  // Boot copy and protection effects
  input wire logic        o_sram_we,
  input wire logic [10:0] o_sram_addr,
  input wire logic        o_proc_hold,
  input wire logic        o_secure_boot,
  input wire logic        o_jtag_enable,
  input wire logic        o_link_access_en,
  input wire logic        o_debug_sync_en,
  input wire logic        o_redundant_en,
  input wire logic [6:0]  o_user_field,
  input wire logic [9:0]  o_usercode_ext
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  logic [11:0] copy_cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Words copied since reset, so the end of the copy can be judged
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      copy_cnt_r <= 12'h000;
    end else if (o_sram_we) begin
      copy_cnt_r <= copy_cnt_r + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read data only in the answer cycle
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000)
    else $error("read data outside its answer cycle");
  // Processor and JTAG held off while the array is copied
  a_hold_blocks_jtag: assert property (o_proc_hold |-> !o_jtag_ready)
    else $error("jtag ready during boot hold");
  a_copy_in_hold: assert property (o_sram_we |-> $past(o_proc_hold) && o_sram_addr < COPY_WORDS)
    else $error("copy word outside boot hold or range");
  a_copy_spacing: assert property (o_sram_we |=> !o_sram_we)
    else $error("copy words too close");
  a_copy_count: assert property ($fell(o_proc_hold) |-> copy_cnt_r + {11'h000, o_sram_we} == COPY_WORDS)
    else $error("hold released with wrong copy count");
  // JTAG answers are single pulses within three cycles
  a_ack_bound: assert property (i_jtag_req && o_jtag_ready |-> ##[1:3] o_jtag_ack)
    else $error("jtag ack missing");
  a_ack_pulse: assert property (o_jtag_ack |=> !o_jtag_ack)
    else $error("jtag ack longer than one cycle");
  a_jtag_refuse: assert property (i_jtag_req && o_jtag_ready && !o_jtag_enable |=> o_jtag_ack && o_jtag_rdata == 32'h00000000)
    else $error("jtag access not refused");
  // Loaded settings do not move until the next reset
  a_config_stable: assert property (!o_proc_hold && !$past(o_proc_hold) |-> $stable({o_secure_boot, o_jtag_enable,
    o_link_access_en, o_debug_sync_en, o_redundant_en, o_user_field, o_usercode_ext}))
    else $error("protection outputs changed after load");
endmodule

bind otp_security_config otp_sec_checker #(.COPY_WORDS(COPY_WORDS)) otp_sec_checker_inst (
  .i_clock, .i_rstn, .i_rd, .o_rdata, .i_jtag_req, .o_jtag_ready, .o_jtag_ack, .o_jtag_rdata,
  .o_sram_we, .o_sram_addr, .o_proc_hold, .o_secure_boot, .o_jtag_enable, .o_link_access_en,
  .o_debug_sync_en, .o_redundant_en, .o_user_field, .o_usercode_ext
);

// *** otp_jtag_host.sv ***
// Behavioural JTAG host reaching the OTP array
`timescale 1ns/100ps
module otp_jtag_host (
  // Clock
  input  wire logic        i_clock,
  // Answer from the block
  input  wire logic        i_ready,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  // Request to the block
  output logic             o_req,
  output logic             o_we,
  output logic      [15:0] o_addr,
  output logic      [31:0] o_wdata
);
  initial begin
    o_req = 1'b0;
    o_we = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h00000000;
  end

  // One access held until taken; released lines show inverted values, not stale ones
  task automatic access(input logic we, input logic [15:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic acked);
    int n;
    acked = 1'b0;
    rdata = 32'hFFFFFFFF;
    @(posedge i_clock);
    o_req <= 1'b1;
    o_we <= we;
    o_addr <= addr;
    o_wdata <= wdata;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clock);
      if (i_ready) break;
    end
    o_req <= 1'b0;
    o_we <= ~we;
    o_addr <= ~addr;
    o_wdata <= ~wdata;
    for (n = 0; n < 8 && !acked; n++) begin
      @(posedge i_clock);
      acked = i_ack;
      rdata = i_rdata;
    end
  endtask
endmodule

// *** otp_security_config_tb.sv ***
// Self-checking bench for the OTP protection block
`timescale 1ns/100ps
module otp_security_config_tb
  import otp_pkg::*;
;
  localparam int unsigned CW = 4;  // Short copy keeps boot quick

  logic        i_clock;
  logic        i_rstn = 1'b0;
  logic [23:0] i_addr = 24'h000000;
  logic [31:0] i_wdata = 32'h00000000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_jtag_req, i_jtag_we, o_jtag_ready, o_jtag_ack, o_sram_we, o_proc_hold;
  logic        o_secure_boot, o_jtag_enable, o_link_access_en, o_debug_sync_en, o_redundant_en;
  logic [15:0] i_jtag_addr;
  logic [31:0] i_jtag_wdata, o_rdata, o_jtag_rdata, o_sram_wdata, copy0;
  logic [10:0] o_sram_addr;
  logic [6:0]  o_user_field;
  logic [9:0]  o_usercode_ext;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  wire logic [21:0] fx = {o_jtag_enable, o_link_access_en, o_secure_boot, o_redundant_en, o_debug_sync_en,
                          o_user_field, o_usercode_ext};

  otp_security_config #(.COPY_WORDS(CW)) otp_security_config_inst (
    .i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_jtag_req, .i_jtag_we, .i_jtag_addr,
    .i_jtag_wdata, .o_jtag_ready, .o_jtag_ack, .o_jtag_rdata, .o_sram_we, .o_sram_addr, .o_sram_wdata,
    .o_proc_hold, .o_secure_boot, .o_jtag_enable, .o_link_access_en, .o_debug_sync_en, .o_redundant_en,
    .o_user_field, .o_usercode_ext
  );
  otp_jtag_host otp_jtag_host_inst (
    .i_clock, .i_ready(o_jtag_ready), .i_ack(o_jtag_ack), .i_rdata(o_jtag_rdata),
    .o_req(i_jtag_req), .o_we(i_jtag_we), .o_addr(i_jtag_addr), .o_wdata(i_jtag_wdata)
  );

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling and capture of the first copied word
  always @(posedge i_clock) begin
    cyc++;
    if (o_sram_we && o_sram_addr == 11'h000) begin
      copy0 <= o_sram_wdata;
    end
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bus cycles; read data stand only in the cycle after the strobe
  task automatic reg_wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [23:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Reset, then wait for the boot copy to release the processor
  task automatic do_reset();
    int n;
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (16) @(posedge i_clock);
    check("rst_hold", {31'h0, o_proc_hold}, 32'h00000001);
    i_rstn <= 1'b1;
    for (n = 0; n < 200 && o_proc_hold !== 1'b0; n++) @(negedge i_clock);
    check("hold", {31'h0, o_proc_hold}, 32'h00000000);
  endtask

  // Address, data, command, then poll busy; refused flag compared
  task automatic prog(input logic [15:0] row, input logic [31:0] d, input logic [15:0] cmd, input logic refuse);
    logic [31:0] st;
    int n;
    reg_wr(RID_ADDR, {16'h0000, row});
    reg_wr(RID_DATA, d);
    reg_wr(RID_CTRL, {16'h0000, cmd});
    n = 0;
    do begin
      reg_rd(RID_CTRL, st);
      n++;
    end while (st[ST_BIT_BUSY] !== 1'b0 && n < 20);
    check("refused", {31'h0, st[ST_BIT_REFUSED]}, {31'h0, refuse});
  endtask

  task automatic rd_row(input logic [15:0] row, output logic [31:0] d);
    prog(row, 32'h00000000, CMD_READ, 1'b0);
    reg_rd(RID_RDATA, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Blank device: everything open, nothing locked
  task automatic t_boot();
    logic [31:0] d;
    check("effects", {10'h000, fx}, {10'h000, 5'h19, 7'h00, 10'h000});
    reg_rd(RID_SEC, d);
    check("sec", d, SEC_RST);
    // Idle status shows loaded and booted, nothing refused
    reg_rd(RID_CTRL, d);
    check("status", d, 32'h0000000C);
    // Unknown command code is refused
    prog(16'h0000, 32'h00000000, 16'h0008, 1'b1);
    reg_rd(24'h000040, d);
    check("unmapped", d, 32'h00000000);
  endtask

  // Programming ORs bits in; redundant rows shut; JTAG reaches the array
  task automatic t_program();
    logic [31:0] d;
    logic        ack;
    prog(16'h0600, 32'h000000F0, CMD_PROGRAM, 1'b0);
    prog(16'h0600, 32'h00000F00, CMD_PROGRAM, 1'b0);
    rd_row(16'h0600, d);
    check("or_row", d, 32'h00000FF0);
    prog(16'h0000, 32'hA5A5A5A5, CMD_PROGRAM, 1'b0);
    prog(16'h0800, 32'h00000001, CMD_PROGRAM, 1'b1);
    otp_jtag_host_inst.access(1'b0, 16'h0600, 32'h00000000, d, ack);
    check("jtag_rd", d, 32'h00000FF0);
    check("jtag_ack", {31'h0, ack}, 32'h00000001);
    otp_jtag_host_inst.access(1'b1, 16'h01FF, 32'h00003C00, d, ack);
    rd_row(16'h01FF, d);
    check("jtag_wr", d, 32'h00003C00);
    // Second command lands while the first is busy and is flagged
    reg_wr(RID_CTRL, {16'h0000, CMD_READ});
    reg_wr(RID_CTRL, {16'h0000, CMD_READ});
    reg_rd(RID_CTRL, d);
    check("busy_refused", d, 32'h0000000E);
  endtask

  // Bits 0 1 5 7 9 13 14, user field 55h, id extension 2ABh; later master lock
  task automatic t_secure();
    logic [31:0] d;
    logic        ack;
    prog(16'h0000, 32'hAAEAE2A3, CMD_PROG_SEC, 1'b0);
    do_reset();
    check("effects", {10'h000, fx}, {10'h000, 5'h06, 7'h55, 10'h2AB});
    reg_rd(RID_SEC, d);
    check("sec", d, 32'hAAEAE2A3);
    check("copy0", copy0, 32'hA5A5A5A5);
    prog(16'h0200, 32'h00000001, CMD_PROGRAM, 1'b1);
    rd_row(16'h0200, d);
    check("locked", d, 32'h00000000);
    prog(16'h0400, 32'h00000001, CMD_PROGRAM, 1'b0);
    prog(16'h0800, 32'h00000001, CMD_PROGRAM, 1'b0);
    otp_jtag_host_inst.access(1'b0, 16'h0600, 32'h00000000, d, ack);
    check("jtag_off", {ack, d[30:0]}, 32'h80000000);
    prog(16'h0000, 32'h00001000, CMD_PROG_SEC, 1'b0);
    do_reset();
    prog(16'h0001, 32'h00000001, CMD_PROGRAM, 1'b1);
    rd_row(16'h0001, d);
    check("master", d, 32'h00000000);
    prog(16'h0000, 32'h00000004, CMD_PROG_SEC, 1'b1);
    reg_rd(RID_SEC, d);
    check("sec_m", d, 32'hAAEAF2A3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    t_boot();
    t_program();
    t_secure();
    results();
  end
endmodule
